// ---- logic/mpdl_top.sv ----
// decision logic of a motor protection relay
// assumes measurements are already scaled and synchronous to i_mclk;
// contact inputs come from pins and are synchronised here
//
// Contract
// - thermal alarm when state exceeds alarm threshold
// - publish time-to-trip estimate once alarm exceeded
// - hot-start block when stopped and state high
// - release block when state below threshold
// - three overcurrent stages, third definite only
// - zero delay setting operates instantaneously
// - overcurrent active in every motor condition
// - two earth stages, pickup and delayed flags
// - earth compared to three times zero-sequence
// - negseq low definite, high inverse time
// - undervoltage off when stopped or start inhibited
// - undervoltage flag after delay below threshold
// - overvoltage flag after delay above threshold
// - long start if current high at timer end
// - successful start when timer expires without trip
// - re-arm long start on authorised flying restart
// - stall flag after start timer expired
// - stall off during start when reacceleration authorised
// - single start event enables stall supervision
// - locked at start if speed switch low
// - stall and locked share one delay
// - thermal trip at full thermal capacity
// - motor shut down when running input low and current not above start level
module mpdl_top (
    input  wire logic                        i_mclk,
    input  wire logic                        i_rstn,
    input  wire logic                        i_tick,
    input  wire logic                        i_motor_running_input,
    input  wire logic                        i_breaker_closed_input,
    input  wire logic                        i_speed_switch_input,
    input  wire logic                        i_reaccel_auth,
    input  wire logic                        i_flying_restart,
    input  wire logic [mpdl_pkg::MEAS_W-1:0] i_phase_cur_max,
    input  wire logic [mpdl_pkg::MEAS_W-1:0] i_zero_seq_cur,
    input  wire logic [mpdl_pkg::MEAS_W-1:0] i_negseq_cur,
    input  wire logic [mpdl_pkg::MEAS_W-1:0] i_volt_ac,
    input  wire logic [15:0]                 i_therm_state,
    input  wire logic [15:0]                 i_therm_rise,
    input  wire logic [15:0]                 i_set_therm_alarm,
    input  wire logic [15:0]                 i_set_start_block,
    input  wire logic                        i_en_start_block,
    input  wire logic                        i_en_oc,
    input  wire logic [mpdl_pkg::MEAS_W-1:0] i_set_oc1,
    input  wire logic [mpdl_pkg::MEAS_W-1:0] i_set_oc2,
    input  wire logic [mpdl_pkg::MEAS_W-1:0] i_set_oc3,
    input  wire mpdl_pkg::mpdl_mode_t        i_mode_oc1,
    input  wire mpdl_pkg::mpdl_mode_t        i_mode_oc2,
    input  wire logic [mpdl_pkg::TMR_W-1:0]  i_dly_oc1,
    input  wire logic [mpdl_pkg::TMR_W-1:0]  i_dly_oc2,
    input  wire logic [mpdl_pkg::TMR_W-1:0]  i_dly_oc3,
    input  wire logic [mpdl_pkg::MEAS_W-1:0] i_set_ef1,
    input  wire logic [mpdl_pkg::MEAS_W-1:0] i_set_ef2,
    input  wire logic [mpdl_pkg::TMR_W-1:0]  i_dly_ef1,
    input  wire logic [mpdl_pkg::TMR_W-1:0]  i_dly_ef2,
    input  wire logic [mpdl_pkg::MEAS_W-1:0] i_set_negseq_def,
    input  wire logic [mpdl_pkg::MEAS_W-1:0] i_set_negseq_inv,
    input  wire logic [mpdl_pkg::TMR_W-1:0]  i_dly_negseq_def,
    input  wire logic [mpdl_pkg::TMR_W-1:0]  i_dly_negseq_inv,
    input  wire logic [mpdl_pkg::MEAS_W-1:0] i_set_uv,
    input  wire logic [mpdl_pkg::MEAS_W-1:0] i_set_ov,
    input  wire logic [mpdl_pkg::TMR_W-1:0]  i_undervoltage_delay,
    input  wire logic [mpdl_pkg::TMR_W-1:0]  i_overvoltage_delay,
    input  wire logic                        i_uv_start_inhibit,
    input  wire mpdl_pkg::mpdl_crit_t        i_start_crit,
    input  wire logic [mpdl_pkg::MEAS_W-1:0] i_set_start_cur,
    input  wire logic [mpdl_pkg::TMR_W-1:0]  i_start_timer,
    input  wire logic [mpdl_pkg::MEAS_W-1:0] i_set_stall_cur,
    input  wire logic [mpdl_pkg::TMR_W-1:0]  i_stall_delay,
    input  wire logic                        i_en_locked_start,
    output logic                             o_therm_alarm,
    output logic [15:0]                      o_time_to_trip,
    output logic                             o_thermal_trip_flag,
    output logic                             o_hot_start_block,
    output logic [2:0]                       o_oc_op,
    output logic [1:0]                       o_ef_pick,
    output logic [1:0]                       o_ef_op,
    output logic                             o_negseq_definite_stage,
    output logic                             o_negseq_inverse_stage,
    output logic                             o_uv_op,
    output logic                             o_ov_op,
    output logic                             o_long_start,
    output logic                             o_start_ok,
    output logic                             o_stall_run,
    output logic                             o_locked_start,
    output logic                             o_starting
);
    import mpdl_pkg::*;

    // ==========================================================
    // reset release and pin synchronisers
    logic [1:0] rst_sync_q;
    logic       rst_n;
    logic [2:0] pin_s1_q;
    logic [2:0] pin_s2_q;
    logic       running;
    logic       brk_closed;
    logic       speed_switch_input;

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // two flops on each contact input
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_q <= 3'h0;
            pin_s2_q <= 3'h0;
        end else begin
            pin_s1_q <= {i_speed_switch_input, i_breaker_closed_input,
                         i_motor_running_input};
            pin_s2_q <= pin_s1_q;
        end
    end
    assign running    = pin_s2_q[0];
    assign brk_closed = pin_s2_q[1];
    assign speed_switch_input   = pin_s2_q[2];

    // ==========================================================
    // thermal alarm, trip, estimate and start blocking
    logic [15:0] ttt_d;
    logic [15:0] headroom;

    // remaining capacity divided by present rise per tick
    always_comb begin
        headroom = (i_therm_state >= THERM_FULL)
                 ? 16'h0000 : THERM_FULL - i_therm_state;
        if (i_therm_rise == 16'h0000) begin
            ttt_d = TTT_MAX;
        end else begin
            ttt_d = headroom / i_therm_rise;
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_therm_alarm       <= 1'b0;
            o_thermal_trip_flag <= 1'b0;
            o_time_to_trip      <= TTT_MAX;
            o_hot_start_block   <= 1'b0;
        end else begin
            o_therm_alarm       <= i_therm_state > i_set_therm_alarm;
            o_thermal_trip_flag <= i_therm_state >= THERM_FULL;
            o_time_to_trip      <= (i_therm_state > i_set_therm_alarm)
                                 ? ttt_d : TTT_MAX;
            o_hot_start_block   <= i_en_start_block && !running
                                && i_therm_state > i_set_start_block;
        end
    end

    // ==========================================================
    // stage pickups and excesses
    logic [MEAS_W+1:0]  resid;
    logic [8:0]         pick;
    logic [8:0][MEAS_W-1:0] excess;
    logic [8:0]         mode;
    logic [8:0][TMR_W-1:0] dly;
    logic [8:0]         op;
    logic               uv_enable;
    logic               uv_pick;
    logic               ov_pick;

    assign resid = (MEAS_W+2)'(i_zero_seq_cur) * (MEAS_W+2)'(RESID_MUL);

    always_comb begin
        // overcurrent stages stay live in every motor condition
        pick[0] = i_en_oc && i_phase_cur_max > i_set_oc1;
        pick[1] = i_en_oc && i_phase_cur_max > i_set_oc2;
        pick[2] = i_en_oc && i_phase_cur_max > i_set_oc3;
        pick[3] = resid > (MEAS_W+2)'(i_set_ef1);
        pick[4] = resid > (MEAS_W+2)'(i_set_ef2);
        pick[5] = i_negseq_cur > i_set_negseq_def;
        pick[6] = i_negseq_cur > i_set_negseq_inv;
        pick[7] = uv_pick;
        pick[8] = ov_pick;
        excess[0] = i_phase_cur_max - i_set_oc1;
        excess[1] = i_phase_cur_max - i_set_oc2;
        excess[2] = '0;
        excess[3] = '0;
        excess[4] = '0;
        excess[5] = '0;
        excess[6] = i_negseq_cur - i_set_negseq_inv;
        excess[7] = '0;
        excess[8] = '0;
        mode = {MPDL_DEFINITE, MPDL_DEFINITE, MPDL_INVERSE,
                MPDL_DEFINITE, MPDL_DEFINITE, MPDL_DEFINITE,
                MPDL_DEFINITE, i_mode_oc2, i_mode_oc1};
        dly = {i_overvoltage_delay, i_undervoltage_delay,
               i_dly_negseq_inv, i_dly_negseq_def, i_dly_ef2,
               i_dly_ef1, i_dly_oc3, i_dly_oc2, i_dly_oc1};
    end

    // undervoltage blocked when stopped or inhibited in start
    assign uv_enable = running && !(i_uv_start_inhibit && o_starting);
    assign uv_pick   = uv_enable && i_volt_ac < i_set_uv;
    assign ov_pick   = i_volt_ac > i_set_ov;

    // one delay stage per element
    genvar g;
    generate
        for (g = 0; g < 9; g++) begin : g_stage
            mpdl_delay u_dly (
                .i_mclk   (i_mclk),
                .i_rst_n  (rst_n),
                .i_tick   (i_tick),
                .i_pick   (pick[g]),
                .i_mode   (mpdl_mode_t'(mode[g])),
                .i_delay  (dly[g]),
                .i_excess (excess[g]),
                .o_op     (op[g])
            );
        end
    endgenerate

    // registered protection outputs
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_oc_op                 <= 3'h0;
            o_ef_pick               <= 2'h0;
            o_ef_op                 <= 2'h0;
            o_negseq_definite_stage <= 1'b0;
            o_negseq_inverse_stage  <= 1'b0;
            o_uv_op                 <= 1'b0;
            o_ov_op                 <= 1'b0;
        end else begin
            o_oc_op                 <= op[2:0];
            o_ef_pick               <= pick[4:3];
            o_ef_op                 <= op[4:3];
            o_negseq_definite_stage <= op[5];
            o_negseq_inverse_stage  <= op[6];
            o_uv_op                 <= op[7];
            o_ov_op                 <= op[8];
        end
    end

    // ==========================================================
    // start supervision: long start, stall, locked rotor
    mpdl_state_t    state_q;
    logic [TMR_W-1:0] start_cnt_q;
    logic [TMR_W-1:0] lock_cnt_q;
    logic [TMR_W-1:0] stall_cnt_q;
    logic           cur_start;
    logic           start_det;
    logic           one_event;
    logic           start_exp;
    logic           any_trip;
    logic           stall_en;

    assign cur_start = i_phase_cur_max > i_set_start_cur;
    // start criterion: current alone, or breaker and current
    assign start_det = (i_start_crit == MPDL_START_CURRENT)
                     ? cur_start : (cur_start && brk_closed);
    assign one_event = (i_start_crit == MPDL_START_BRK_CUR)
                     && (cur_start ^ brk_closed);
    assign start_exp = (state_q == MPDL_ST_START)
                     && i_tick && start_cnt_q >= i_start_timer;
    assign any_trip  = o_thermal_trip_flag || |o_oc_op || |o_ef_op
                     || o_negseq_inverse_stage || o_locked_start;
    assign o_starting = (state_q == MPDL_ST_START);

    // start state: idle until start, start timer, then running
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q     <= MPDL_ST_IDLE;
            start_cnt_q <= '0;
        end else begin
            case (state_q)
                MPDL_ST_IDLE: begin
                    start_cnt_q <= '0;
                    if (start_det) begin
                        state_q <= MPDL_ST_START;
                    end else if (one_event) begin
                        state_q <= MPDL_ST_RUNNING;
                    end
                end
                MPDL_ST_START: begin
                    if (start_exp) begin
                        state_q <= MPDL_ST_RUNNING;
                    end else if (i_tick) begin
                        start_cnt_q <= start_cnt_q + 1'b1;
                    end
                end
                MPDL_ST_RUNNING: begin
                    start_cnt_q <= '0;
                    if (i_reaccel_auth && i_flying_restart) begin
                        state_q <= MPDL_ST_START;
                    end else if (!running && !cur_start) begin
                        state_q <= MPDL_ST_IDLE;
                    end
                end
                default: begin
                    state_q <= MPDL_ST_IDLE;
                end
            endcase
        end
    end

    // end-of-start outcomes
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_long_start <= 1'b0;
            o_start_ok   <= 1'b0;
        end else begin
            if (start_exp && cur_start) begin
                o_long_start <= 1'b1;
            end else if (state_q == MPDL_ST_IDLE && start_det) begin
                o_long_start <= 1'b0;
            end
            o_start_ok <= start_exp && !any_trip;
        end
    end

    // locked rotor at start shares the stall delay
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            lock_cnt_q     <= '0;
            o_locked_start <= 1'b0;
        end else if (state_q != MPDL_ST_START || !i_en_locked_start) begin
            lock_cnt_q <= '0;
            if (state_q == MPDL_ST_IDLE) begin
                o_locked_start <= 1'b0;
            end
        end else if (lock_cnt_q >= i_stall_delay) begin
            o_locked_start <= o_locked_start || !speed_switch_input;
        end else if (i_tick) begin
            lock_cnt_q <= lock_cnt_q + 1'b1;
        end
    end

    // stall while running, only after the start period
    assign stall_en = (state_q == MPDL_ST_RUNNING)
                   && !(i_reaccel_auth && o_starting);
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            stall_cnt_q <= '0;
            o_stall_run <= 1'b0;
        end else if (!stall_en
                     || !(i_phase_cur_max > i_set_stall_cur)) begin
            stall_cnt_q <= '0;
            o_stall_run <= 1'b0;
        end else if (stall_cnt_q > i_stall_delay) begin
            o_stall_run <= 1'b1;
        end else if (i_tick) begin
            stall_cnt_q <= stall_cnt_q + 1'b1;
        end
    end
endmodule

// ---- common/mpdl_pkg.sv ----
// package for the motor protection decision logic
// assumes measurements arrive scaled to a common unsigned format
package mpdl_pkg;
    // measurement and setting widths
    localparam int MEAS_W   = 16;
    localparam int TMR_W    = 16;
    // residual current is three times the zero-sequence component
    localparam int RESID_MUL = 3;
    // thermal state full capacity (scaled so 0x8000 = 100 %)
    localparam logic [15:0] THERM_FULL = 16'h8000;
    // time-to-trip value when there is no alarm or no thermal rise
    localparam logic [15:0] TTT_MAX    = 16'hFFFF;
    // inverse-time accumulator full scale
    localparam logic [31:0] INV_FULL   = 32'h0010_0000;
    // delay mode codes
    typedef enum logic [0:0] {
        MPDL_DEFINITE = 1'b0,
        MPDL_INVERSE  = 1'b1
    } mpdl_mode_t;
    // start-detection criterion codes
    typedef enum logic [0:0] {
        MPDL_START_CURRENT = 1'b0,
        MPDL_START_BRK_CUR = 1'b1
    } mpdl_crit_t;
    // start supervision states
    typedef enum logic [1:0] {
        MPDL_ST_IDLE    = 2'b00,
        MPDL_ST_START   = 2'b01,
        MPDL_ST_RUNNING = 2'b10
    } mpdl_state_t;
endpackage

// ---- logic/mpdl_delay.sv ----
// one pickup-delay stage: definite count or inverse accumulation
// assumes i_tick is a one-cycle pulse once per power cycle
module mpdl_delay (
    input  wire logic                        i_mclk,
    input  wire logic                        i_rst_n,
    input  wire logic                        i_tick,
    input  wire logic                        i_pick,
    input  wire mpdl_pkg::mpdl_mode_t        i_mode,
    input  wire logic [mpdl_pkg::TMR_W-1:0]  i_delay,
    input  wire logic [mpdl_pkg::MEAS_W-1:0] i_excess,
    output logic                             o_op
);
    import mpdl_pkg::*;

    logic [31:0] acc_q;
    logic [31:0] step;
    logic        done;

    // inverse mode adds excess squared per tick, definite adds one
    always_comb begin
        step = (i_mode == MPDL_INVERSE)
             ? 32'(i_excess) * 32'(i_excess) : 32'h0000_0001;
        done = (i_mode == MPDL_INVERSE)
             ? (acc_q >= 32'(i_delay) * (INV_FULL >> 16))
             : (acc_q >= 32'(i_delay));
    end

    // timer clears when pickup drops out
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            acc_q <= 32'h0000_0000;
        end else if (!i_pick) begin
            acc_q <= 32'h0000_0000;
        end else if (i_tick && !done) begin
            acc_q <= (acc_q > 32'hFFFF_FFFF - step)
                   ? 32'hFFFF_FFFF : acc_q + step;
        end
    end

    // zero delay operates at once
    assign o_op = i_pick && done;
endmodule

// ---- bench/mpdl_feeder.sv ----
// feeder model: per-power-cycle measurement tick
// assumes one clock; tick period set by TICK_DIV clocks
module mpdl_feeder #(
    parameter int TICK_DIV = 4
) (
    input  wire logic i_mclk,
    output logic      o_tick
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // tick divider
    logic [7:0] div_q = 8'h00;
    // one-cycle tick, set by nonblocking on the edge
    always @(posedge i_mclk) begin
        div_q  <= (div_q == 8'(TICK_DIV - 1)) ? 8'h00 : div_q + 8'h01;
        o_tick <= (div_q == 8'(TICK_DIV - 1));
    end
endmodule

// ---- bench/mpdl_checker.sv ----
// checks decision outputs against their causes
// assumes a bind onto mpdl_top, ports by name
module mpdl_checker
    import mpdl_pkg::*;
(
    input wire logic              i_mclk,
    input wire logic              i_rstn,
    input wire logic              i_en_oc,
    input wire logic              i_uv_start_inhibit,
    input wire logic [15:0]       i_therm_state,
    input wire logic [15:0]       i_set_therm_alarm,
    input wire logic [15:0]       i_set_start_block,
    input wire logic [MEAS_W-1:0] i_zero_seq_cur,
    input wire logic [MEAS_W-1:0] i_set_ef1,
    input wire logic              o_therm_alarm,
    input wire logic [15:0]       o_time_to_trip,
    input wire logic              o_thermal_trip_flag,
    input wire logic              o_hot_start_block,
    input wire logic [2:0]        o_oc_op,
    input wire logic [1:0]        o_ef_pick,
    input wire logic              o_uv_op,
    input wire logic              o_long_start,
    input wire logic              o_start_ok,
    input wire logic              o_stall_run,
    input wire logic              o_starting
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    // ==========================================
    // settle window after reset release
    logic [2:0] up_q;
    logic       up;
    // four edges: the synced reset lets go after two, then outputs register
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            up_q <= 3'h0;
        end else if (!up) begin
            up_q <= up_q + 3'h1;
        end
    end
    assign up = (up_q == 3'h4);
    // start timer has just run out
    sequence s_start_end;
        $past(o_starting) && !o_starting;
    endsequence
    // ==========================================
    // properties
    a_alarm_level: assert property (up |->
        o_therm_alarm == ($past(i_therm_state) > $past(i_set_therm_alarm)))
        else $error("alarm level wrong");
    a_trip_full: assert property (up |->
        o_thermal_trip_flag == ($past(i_therm_state) >= THERM_FULL))
        else $error("trip level wrong");
    a_ttt_idle: assert property (up && !o_therm_alarm |->
        o_time_to_trip == TTT_MAX) else $error("estimate without alarm");
    a_block_hot: assert property (up && o_hot_start_block |->
        $past(i_therm_state) > $past(i_set_start_block))
        else $error("block on cool motor");
    a_oc_gated: assert property ((!i_en_oc) [*4] |->
        o_oc_op == 3'h0) else $error("overcurrent while off");
    a_ef_resid: assert property (up |->
        o_ef_pick[0] == (18'd3 * $past(i_zero_seq_cur) > $past(i_set_ef1)))
        else $error("earth pickup not residual");
    a_uv_inhibit: assert property (o_starting && i_uv_start_inhibit |=>
        !o_uv_op) else $error("undervoltage in inhibited start");
    a_stall_late: assert property ($rose(o_stall_run) |->
        !$past(o_starting)) else $error("stall during start");
    a_ok_pulse: assert property (o_start_ok |->
        s_start_end ##1 !o_start_ok) else $error("start ok misplaced");
    a_long_end: assert property ($rose(o_long_start) |->
        s_start_end) else $error("long start off timer end");
endmodule

bind mpdl_top mpdl_checker u_chk (.*);

// ---- bench/mpdl_top_test.sv ----
// self-checking bench for the protection decision logic
// assumes mpdl_top, mpdl_feeder and the checker bind
module mpdl_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    import mpdl_pkg::*;
    // ==========================================
    // stimulus and outputs
    bit i_mclk, i_rstn, i_tick, i_motor_running_input, i_reaccel_auth;
    bit i_breaker_closed_input, i_speed_switch_input, i_flying_restart;
    bit i_en_start_block, i_en_oc, i_en_locked_start, i_uv_start_inhibit;
    bit [15:0] i_phase_cur_max, i_zero_seq_cur, i_negseq_cur, i_volt_ac;
    bit [15:0] i_therm_state, i_therm_rise, i_set_therm_alarm, i_set_oc1;
    bit [15:0] i_set_start_block, i_set_oc2, i_set_oc3, i_dly_oc1, i_dly_oc2;
    bit [15:0] i_dly_oc3, i_set_ef1, i_set_ef2, i_dly_ef1, i_dly_ef2, i_set_uv;
    bit [15:0] i_set_negseq_def, i_set_negseq_inv, i_dly_negseq_def, i_set_ov;
    bit [15:0] i_dly_negseq_inv, i_undervoltage_delay, i_overvoltage_delay;
    bit [15:0] i_start_timer, i_stall_delay;
    bit [15:0] i_set_start_cur = 16'hFFFF, i_set_stall_cur = 16'hFFFF;
    mpdl_mode_t i_mode_oc1 = MPDL_DEFINITE, i_mode_oc2 = MPDL_INVERSE;
    mpdl_crit_t i_start_crit = MPDL_START_CURRENT;
    logic o_therm_alarm, o_thermal_trip_flag, o_hot_start_block, o_uv_op;
    logic o_negseq_definite_stage, o_negseq_inverse_stage, o_ov_op;
    logic o_long_start, o_start_ok, o_stall_run, o_locked_start, o_starting;
    logic [15:0] o_time_to_trip;
    logic [2:0] o_oc_op;
    logic [1:0] o_ef_pick, o_ef_op;
    int fail_count = 0, comparisons = 0, seen;
    // clock, tick source and design
    always #5 i_mclk = ~i_mclk;
    mpdl_feeder #(.TICK_DIV(4)) feeder (.i_mclk(i_mclk), .o_tick(i_tick));
    mpdl_top DUT (.*);
    // ==========================================
    // helpers
    task automatic step(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [15:0] exp, got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // watchdog: tests take about 350 clocks
    initial begin
        #20000;
        fail_count++;
        summarize();
    end
    // ==========================================
    // test sequence
    initial begin
        step(10);
        i_rstn = 1;
        step(6);
        // thermal alarm and trip
        {i_set_therm_alarm, i_therm_rise} = {16'h6000, 16'h0100};
        i_therm_state = 16'h7000;
        step(3);
        chk("alarm", 1'h1, o_therm_alarm);
        chk("ttt", 16'h0010, o_time_to_trip);
        chk("trip", 1'h0, o_thermal_trip_flag);
        i_therm_state = 16'h8000;
        step(3);
        chk("trip", 1'h1, o_thermal_trip_flag);
        i_therm_state = 16'h6000;
        step(3);
        chk("alarm", 1'h0, o_therm_alarm);
        chk("ttt", 16'hFFFF, o_time_to_trip);
        // hot-start block
        {i_en_start_block, i_set_start_block} = {1'b1, 16'h5000};
        i_therm_state = 16'h5001;
        step(3);
        chk("block", 1'h1, o_hot_start_block);
        i_therm_state = 16'h4FFF;
        step(3);
        chk("block", 1'h0, o_hot_start_block);
        {i_therm_state, i_motor_running_input} = {16'h7000, 1'b1};
        step(6);
        chk("block", 1'h0, o_hot_start_block);
        {i_therm_state, i_motor_running_input} = {16'h0000, 1'b0};
        // overcurrent, motor stopped
        i_en_oc = 1;
        {i_set_oc1, i_dly_oc1} = {16'h0800, 16'h0003};
        {i_set_oc2, i_dly_oc2, i_set_oc3} = {16'h0F00, 16'h2000, 16'h1000};
        i_phase_cur_max = 16'h1001;
        step(3);
        chk("oc", 3'h4, o_oc_op);
        step(5);
        chk("oc1", 1'h0, o_oc_op[0]);
        step(12);
        chk("oc", 3'h7, o_oc_op);
        i_en_oc = 0;
        step(5);
        chk("oc off", 3'h0, o_oc_op);
        i_phase_cur_max = '0;
        // earth stages
        {i_set_ef1, i_set_ef2, i_dly_ef1} = {16'h02FF, 16'h0300, 16'h0001};
        i_zero_seq_cur = 16'h0100;
        step(3);
        chk("ef pick", 2'h1, o_ef_pick);
        step(12);
        chk("ef op", 2'h1, o_ef_op);
        i_set_ef2 = 16'h0200;
        step(3);
        chk("ef op", 2'h3, o_ef_op);
        i_zero_seq_cur = '0;
        step(3);
        chk("ef op", 2'h0, o_ef_op);
        // unbalance stages
        {i_set_negseq_def, i_dly_negseq_def} = {16'h0100, 16'h0002};
        {i_set_negseq_inv, i_dly_negseq_inv} = {16'h0200, 16'h0001};
        i_negseq_cur = 16'h0300;
        step(20);
        chk("ns inv", 1'h1, o_negseq_inverse_stage);
        i_negseq_cur = 16'h0180;
        step(3);
        chk("ns inv", 1'h0, o_negseq_inverse_stage);
        chk("ns def", 1'h1, o_negseq_definite_stage);
        i_negseq_cur = '0;
        // under- and overvoltage
        {i_set_uv, i_set_ov} = {16'h1000, 16'h3000};
        {i_undervoltage_delay, i_overvoltage_delay} = {16'h0002, 16'h0002};
        i_volt_ac = 16'h0800;
        step(20);
        chk("uv", 1'h0, o_uv_op);
        i_motor_running_input = 1;
        step(20);
        chk("uv", 1'h1, o_uv_op);
        i_volt_ac = 16'h3001;
        step(20);
        chk("ov", 1'h1, o_ov_op);
        // locked, too long start
        i_set_start_cur = 16'h0500;
        i_set_stall_cur = 16'h0300;
        {i_start_timer, i_stall_delay} = {16'h0006, 16'h0002};
        {i_en_locked_start, i_uv_start_inhibit} = 2'b11;
        {i_volt_ac, i_phase_cur_max} = {16'h0800, 16'h0600};
        step(3);
        chk("starting", 1'h1, o_starting);
        step(12);
        chk("uv", 1'h0, o_uv_op);
        chk("locked", 1'h1, o_locked_start);
        step(16);
        chk("long", 1'h1, o_long_start);
        step(20);
        chk("stall", 1'h1, o_stall_run);
        // clean start
        {i_motor_running_input, i_phase_cur_max} = {1'b0, 16'h0000};
        step(6);
        {i_speed_switch_input, i_volt_ac} = {1'b1, 16'h2000};
        {i_motor_running_input, i_phase_cur_max} = {1'b1, 16'h0600};
        step(8);
        i_phase_cur_max = 16'h0200;
        seen = 0;
        repeat (40) begin
            step(1);
            if (o_start_ok === 1'b1) seen++;
        end
        chk("start ok", 16'h0001, 16'(seen));
        chk("long", 1'h0, o_long_start);
        chk("locked", 1'h0, o_locked_start);
        // flying restart
        {i_reaccel_auth, i_phase_cur_max} = {1'b1, 16'h0600};
        i_flying_restart = 1;
        step(1);
        i_flying_restart = 0;
        step(2);
        chk("starting", 1'h1, o_starting);
        step(14);
        chk("stall", 1'h0, o_stall_run);
        // current without breaker
        {i_reaccel_auth, i_motor_running_input} = 2'b00;
        i_phase_cur_max = '0;
        step(40);
        i_start_crit = MPDL_START_BRK_CUR;
        {i_motor_running_input, i_phase_cur_max} = {1'b1, 16'h0600};
        step(3);
        chk("starting", 1'h0, o_starting);
        step(20);
        chk("stall", 1'h1, o_stall_run);
        summarize();
    end
endmodule
